// ===== hdl/ctu_regs.svh
`ifndef CTU_REGS_SVH
`define CTU_REGS_SVH

// Byte addresses on APB
`define CTU_ADDR_CTRL0      12'h000
`define CTU_ADDR_CTRL1      12'h004
`define CTU_ADDR_CNT_LO     12'h008
`define CTU_ADDR_CNT_HI     12'h00C
`define CTU_ADDR_CMPA_LO    12'h010
`define CTU_ADDR_CMPA_HI    12'h014
`define CTU_ADDR_FLAGS      12'h018

// Control 0 fields
`define CTU_C0_PAUSE        7
`define CTU_C0_CKSEL_HI     6
`define CTU_C0_CKSEL_LO     4
`define CTU_C0_ON           3
`define CTU_C0_PER_HI       2
`define CTU_C0_PER_LO       0

// Control 1 fields
`define CTU_C1_MODE_HI      7
`define CTU_C1_MODE_LO      6
`define CTU_C1_PIN_HI       5
`define CTU_C1_PIN_LO       4
`define CTU_C1_OC           3
`define CTU_C1_POL          2
`define CTU_C1_DPX          1
`define CTU_C1_CCLR         0

// Reset values
`define CTU_RST_CTRL        8'h00
`define CTU_RST_CMPA        10'h000

// Prescaler ratios
`define CTU_DIV_SYS4        4
`define CTU_DIV_HI16        16
`define CTU_DIV_HI64        64

`endif

// ===== hdl/ctu_pkg.sv
package ctu_pkg;

    typedef enum logic [1:0] {
        CTU_MODE_CMP   = 2'h0,
        CTU_MODE_UNDEF = 2'h1,
        CTU_MODE_PWM   = 2'h2,
        CTU_MODE_TMR   = 2'h3
    } ctu_mode_e;

    typedef struct packed {
        logic       pause;
        logic [2:0] cksel;
        logic       on;
        logic [2:0] period;
    } ctu_ctrl0_s;

    typedef struct packed {
        ctu_mode_e  mode;
        logic [1:0] pin_fn;
        logic       oc;
        logic       pol;
        logic       dpx;
        logic       cclr;
    } ctu_ctrl1_s;

    typedef struct packed {
        logic       clk_sys;
        logic       clk_hi;
        logic       clk_sub;
        logic       ext_pin;
    } ctu_clkin_s;

endpackage

// ===== hdl/ctu_timer.sv
// Behaviour
// - Ten-bit up counter advancing once per selected timer clock tick.
// - Period comparator matches coarse value against counter bits 9..7.
// - Compare-A matches full ten-bit compare value against whole counter.
// - Counter-on rising edge zeroes counter; software cannot otherwise alter it.
// - Counter-on low stops counting and holds value.
// - Pause freezes counter, stays powered, resumes from held value.
// - Three-bit clock select: sys/4, sys, hi/16, hi/64, sub, sub, pin rise, fall.
// - Period matches every 128 clocks times code; code zero means 1024.
// - Coarse period zero lets counter overflow at maximum.
// - Mode field: 00 compare output, 10 PWM, 11 timer; 01 undefined.
// - Compare mode on A match: keep, low, high or toggle pin.
// - PWM pin field: force inactive, force active, PWM waveform; 11 undefined.
// - Output control sets initial level (compare and timer modes) or active level (PWM).
// - Counter-on rising edge restores pin initial level in compare or timer mode.
// - Polarity bit inverts pin in every mode, timer mode included.
// - Swap bit exchanges period and duty roles of the two comparators.
// - Outside PWM clear on A match or period match/overflow per select.
// - Clear-select bit ignored in PWM mode.
// - Live counter readable as low byte and two-bit high byte.
// - Interrupt request raised while compare-A flag or period flag is set.
// - Low byte moves through buffer only on high-byte access.
// - Compare mode pin changes only on compare-A match or counter-on rising edge.
// - Clear-select high suppresses the period flag outside PWM mode.
// - PWM duty at or above period gives full duty.
`include "ctu_regs.svh"

module ctu_timer #(
    parameter int CNT_W = 10
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire ctu_pkg::ctu_clkin_s clk_in,
    output logic                   timer_output_pin,
    output logic                   timer_output_en,
    output logic                   compare_a_flag,
    output logic                   period_compare_flag,
    output logic                   timer_irq,
    output logic                   unit_powered
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and bus decode
    ctu_pkg::ctu_ctrl0_s   c0_r;
    ctu_pkg::ctu_ctrl1_s   c1_r;
    logic [CNT_W-1:0]      cnt_r;
    logic [CNT_W-1:0]      cmpa_r;
    logic [7:0]            wbuf_r;
    logic [7:0]            rbuf_r;
    logic [7:0]            cmpa_rbuf_r;
    logic                  on_d_r;
    logic                  pin_r;
    logic                  af_r;
    logic                  pf_r;
    logic [1:0]            ext_sync_r;
    logic [1:0]            hi_sync_r;
    logic [1:0]            sub_sync_r;
    logic                  ext_d_r;
    logic                  hi_d_r;
    logic                  sub_d_r;
    logic [5:0]            pre_r;
    logic [5:0]            hdiv64_r;
    logic                  pwm_act_r;

    wire wr_en   = psel && penable && pwrite;
    wire rd_en   = psel && penable && !pwrite;
    wire hit_c0  = (paddr == `CTU_ADDR_CTRL0);
    wire hit_c1  = (paddr == `CTU_ADDR_CTRL1);
    wire hit_dl  = (paddr == `CTU_ADDR_CNT_LO);
    wire hit_dh  = (paddr == `CTU_ADDR_CNT_HI);
    wire hit_al  = (paddr == `CTU_ADDR_CMPA_LO);
    wire hit_ah  = (paddr == `CTU_ADDR_CMPA_HI);
    wire hit_fl  = (paddr == `CTU_ADDR_FLAGS);
    wire hit_any = hit_c0 || hit_c1 || hit_dl || hit_dh || hit_al || hit_ah || hit_fl;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and clock tick generation
    // Divider tap reaches its last count
    function automatic logic div_due(input logic [5:0] cnt, input int unsigned ratio);
        return (cnt & 6'(ratio - 1)) == 6'(ratio - 1);
    endfunction

    wire ext_rise   = ext_sync_r[1] && !ext_d_r;
    wire ext_fall   = !ext_sync_r[1] && ext_d_r;
    wire hi_rise    = hi_sync_r[1] && !hi_d_r;
    wire sub_rise   = sub_sync_r[1] && !sub_d_r;
    wire sys4_tick  = div_due(pre_r, `CTU_DIV_SYS4);
    wire hi16_tick  = hi_rise && div_due(hdiv64_r, `CTU_DIV_HI16);
    wire hi64_tick  = hi_rise && div_due(hdiv64_r, `CTU_DIV_HI64);

    logic tick;
    always_comb begin
        case (c0_r.cksel)
            3'h0:    tick = sys4_tick;
            3'h1:    tick = 1'b1;
            3'h2:    tick = hi16_tick;
            3'h3:    tick = hi64_tick;
            3'h4:    tick = sub_rise;
            3'h5:    tick = sub_rise;
            3'h6:    tick = ext_rise;
            default: tick = ext_fall;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comparators and clear logic
    wire is_pwm   = (c1_r.mode == ctu_pkg::CTU_MODE_PWM);
    wire is_tmr   = (c1_r.mode == ctu_pkg::CTU_MODE_TMR);
    wire run      = c0_r.on && !c0_r.pause;
    wire on_rise  = c0_r.on && !on_d_r;
    wire step     = run && tick;
    wire [CNT_W-1:0] cnt_inc = cnt_r + 10'h001;
    wire ovf      = step && (cnt_r == 10'h3FF);
    wire p_match  = step && (c0_r.period != 3'h0)
                    && (cnt_inc[9:7] == c0_r.period) && (cnt_inc[6:0] == 7'h00);
    wire a_match  = step && (cmpa_r != 10'h000) && (cnt_inc == cmpa_r);
    wire p_full   = step && (c0_r.period == 3'h0) && ovf;

    // Period source in PWM selected by swap bit
    wire pwm_clr  = c1_r.dpx ? a_match : (p_match || p_full);
    wire cmp_clr  = c1_r.cclr ? a_match : (p_match || p_full);
    wire clr_cnt  = is_pwm ? pwm_clr : cmp_clr;
    wire pf_evt   = (is_pwm || !c1_r.cclr) && (p_match || p_full);
    wire af_evt   = a_match;

    ////////////////////////////////////////////////////////////////////////////
    // PWM duty
    wire [CNT_W-1:0] per_val  = {c0_r.period, 7'h00};
    wire [CNT_W:0]   per_len  = (c0_r.period == 3'h0) ? 11'h400 : {1'b0, per_val};
    wire [CNT_W:0]   duty_len = c1_r.dpx ? per_len : {1'b0, cmpa_r};
    wire [CNT_W:0]   prd_len  = c1_r.dpx ? {1'b0, cmpa_r} : per_len;
    wire duty_full = (duty_len >= prd_len);
    wire duty_hit  = c1_r.dpx ? (p_match || p_full) : a_match;
    wire duty_zero = (duty_len == 11'h000);

    ////////////////////////////////////////////////////////////////////////////
    // Sequential logic
    // External pin synchroniser and edge memory
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync_r <= 2'h0;
            ext_d_r    <= 1'b0;
        end else begin
            ext_sync_r <= {ext_sync_r[0], clk_in.ext_pin};
            ext_d_r    <= ext_sync_r[1];
        end
    end

    // High clock synchroniser and edge memory
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_sync_r <= 2'h0;
            hi_d_r    <= 1'b0;
        end else begin
            hi_sync_r <= {hi_sync_r[0], clk_in.clk_hi};
            hi_d_r    <= hi_sync_r[1];
        end
    end

    // Sub clock synchroniser and edge memory
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_sync_r <= 2'h0;
            sub_d_r    <= 1'b0;
        end else begin
            sub_sync_r <= {sub_sync_r[0], clk_in.clk_sub};
            sub_d_r    <= sub_sync_r[1];
        end
    end

    // System clock prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r <= 6'h00;
        end else begin
            pre_r <= pre_r + 6'h01;
        end
    end

    // High clock prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hdiv64_r <= 6'h00;
        end else if (hi_rise) begin
            hdiv64_r <= hdiv64_r + 6'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c0_r <= ctu_pkg::ctu_ctrl0_s'(`CTU_RST_CTRL);
            c1_r <= ctu_pkg::ctu_ctrl1_s'(`CTU_RST_CTRL);
        end else if (wr_en) begin
            if (hit_c0) begin
                c0_r <= ctu_pkg::ctu_ctrl0_s'(pwdata[7:0]);
            end else if (hit_c1) begin
                c1_r <= ctu_pkg::ctu_ctrl1_s'(pwdata[7:0]);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmpa_r      <= `CTU_RST_CMPA;
            wbuf_r      <= 8'h00;
            rbuf_r      <= 8'h00;
            cmpa_rbuf_r <= 8'h00;
        end else begin
            if (wr_en && hit_al) begin
                wbuf_r <= pwdata[7:0];
            end else if (wr_en && hit_ah) begin
                cmpa_r <= {pwdata[1:0], wbuf_r};
            end
            if (rd_en && hit_dh) begin
                rbuf_r <= cnt_r[7:0];
            end
            if (rd_en && hit_ah) begin
                cmpa_rbuf_r <= cmpa_r[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= 10'h000;
            on_d_r <= 1'b0;
        end else begin
            on_d_r <= c0_r.on;
            if (on_rise) begin
                cnt_r <= 10'h000;
            end else if (step) begin
                cnt_r <= (clr_cnt || ovf) ? 10'h000 : cnt_inc;
            end
        end
    end

    // Flags: set wins over software clear
    wire fl_clr = wr_en && hit_fl;
    wire af_clr = fl_clr && pwdata[0];
    wire pf_clr = fl_clr && pwdata[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            af_r <= 1'b0;
        end else begin
            af_r <= af_evt || (af_r && !af_clr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pf_r <= 1'b0;
        end else begin
            pf_r <= pf_evt || (pf_r && !pf_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare mode pin level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_r <= 1'b0;
        end else if (on_rise) begin
            pin_r <= c1_r.oc;
        end else if (!is_pwm && af_evt) begin
            case (c1_r.pin_fn)
                2'h1:    pin_r <= 1'b0;
                2'h2:    pin_r <= 1'b1;
                2'h3:    pin_r <= !pin_r;
                default: pin_r <= pin_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // PWM active phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_act_r <= 1'b0;
        end else if (on_rise) begin
            pwm_act_r <= 1'b1;
        end else if (is_pwm && step && pwm_clr) begin
            pwm_act_r <= 1'b1;
        end else if (is_pwm && step && duty_hit) begin
            pwm_act_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output pin
    logic pwm_lvl;
    always_comb begin
        case (c1_r.pin_fn)
            2'h0:    pwm_lvl = !c1_r.oc;
            2'h1:    pwm_lvl = c1_r.oc;
            2'h2:    pwm_lvl = ((pwm_act_r || duty_full) && !duty_zero) ? c1_r.oc : !c1_r.oc;
            default: pwm_lvl = !c1_r.oc;
        endcase
    end
    wire pin_raw = is_pwm ? pwm_lvl : pin_r;
    logic pin_out_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_r <= 1'b0;
        end else begin
            pin_out_r <= pin_raw ^ c1_r.pol;
        end
    end
    assign timer_output_pin    = pin_out_r;
    assign timer_output_en     = is_tmr;
    assign compare_a_flag      = af_r;
    assign period_compare_flag = pf_r;
    assign timer_irq           = af_r || pf_r;
    assign unit_powered        = c0_r.on;

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (hit_c0) begin
            prdata[7:0] = c0_r;
        end else if (hit_c1) begin
            prdata[7:0] = c1_r;
        end else if (hit_dl) begin
            prdata[7:0] = rbuf_r;
        end else if (hit_dh) begin
            prdata[1:0] = cnt_r[9:8];
        end else if (hit_al) begin
            prdata[7:0] = cmpa_rbuf_r;
        end else if (hit_ah) begin
            prdata[1:0] = cmpa_r[9:8];
        end else if (hit_fl) begin
            prdata[1:0] = {pf_r, af_r};
        end
    end

endmodule // ctu_timer

// ===== dv/ctu_timer_sva.sv
`include "ctu_regs.svh"

module ctu_timer_sva #(
    parameter int CNT_W = 10
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        timer_output_pin,
    input wire logic        timer_output_en,
    input wire logic        compare_a_flag,
    input wire logic        period_compare_flag,
    input wire logic        timer_irq,
    input wire logic        unit_powered
);
    logic [1:0] md_q;
    logic       cclr_q;
    logic       lvl_q;
    wire        acc = psel && penable;
    wire        wr0 = acc && pwrite && paddr == `CTU_ADDR_CTRL0;
    wire        wr1 = acc && pwrite && paddr == `CTU_ADDR_CTRL1;

    ////////////////////////////////////////////////////////////////
    // Shadow of control 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            md_q   <= 2'h0;
            cclr_q <= 1'b0;
            lvl_q  <= 1'b0;
        end else if (wr1) begin
            md_q   <= pwdata[7:6];
            cclr_q <= pwdata[0];
            lvl_q  <= pwdata[3] ^ pwdata[2];
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_irq_flags_or: assert property (timer_irq == (compare_a_flag | period_compare_flag))
        else $error("irq differs from flags");
    a_powered_on_bit: assert property (wr0 |=> unit_powered == $past(pwdata[3]))
        else $error("powered does not follow on bit");
    a_ready_zero_wait: assert property (acc |-> pready)
        else $error("pready low in access");
    a_err_unmapped: assert property (acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > `CTU_ADDR_FLAGS))
        else $error("pslverr wrong");
    a_hi_byte_zero: assert property (acc && !pwrite && (paddr == `CTU_ADDR_CNT_HI || paddr == `CTU_ADDR_CMPA_HI)
        |-> prdata[31:2] == 30'h0)
        else $error("high byte upper bits set");
    a_en_timer_mode: assert property (wr1 |=> ##1 timer_output_en == (md_q == 2'h3))
        else $error("output enable wrong for mode");
    a_period_quiet: assert property ($rose(period_compare_flag) |-> !(cclr_q && md_q != 2'h2))
        else $error("period flag with clear select high");
    a_init_level: assert property ($rose(unit_powered) && md_q == 2'h0 |-> ##[1:3] timer_output_pin == lvl_q)
        else $error("pin not at initial level");

    c_ctrl_write: cover property (wr1);
    c_a_match: cover property ($rose(compare_a_flag));
    c_p_match: cover property ($rose(period_compare_flag));
endmodule // ctu_timer_sva

bind ctu_timer ctu_timer_sva #(.CNT_W(CNT_W)) i_ctu_timer_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_output_pin(timer_output_pin), .timer_output_en(timer_output_en),
    .compare_a_flag(compare_a_flag), .period_compare_flag(period_compare_flag), .timer_irq(timer_irq),
    .unit_powered(unit_powered));

// ===== dv/ctu_timer_tb_top.sv
`include "ctu_regs.svh"

module ctu_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                pclk = 1'b0;
    logic                presetn = 1'b0;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [11:0]         paddr = 12'h0;
    logic [31:0]         pwdata = 32'h0;
    ctu_pkg::ctu_clkin_s clk_in = '0;
    logic [31:0]         prdata, rd;
    logic                pready, pslverr, err, pin, pin_en, fa, fp, irq, pwr, o, p;
    logic [9:0]          cmp, v, a;
    logic [2:0]          per;
    logic [4:0]          cyc = 5'h0;
    int                  error_cnt = 0;
    int                  check_count = 0;
    int                  n, e;

    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 5'h1;
        clk_in.clk_hi <= ~clk_in.clk_hi;
        clk_in.clk_sub <= cyc[3];
    end

    ctu_timer i_ctu_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .clk_in(clk_in),
        .timer_output_pin(pin), .timer_output_en(pin_en), .compare_a_flag(fa), .period_compare_flag(fp),
        .timer_irq(irq), .unit_powered(pwr));

    ////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++t < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdcnt(output logic [9:0] c);
        apb(1'b0, `CTU_ADDR_CNT_HI, 32'h0);
        c[9:8] = rd[1:0];
        apb(1'b0, `CTU_ADDR_CNT_LO, 32'h0);
        c[7:0] = rd[7:0];
    endtask

    task automatic cfg(input logic [7:0] c0, input logic [7:0] c1, input logic [9:0] ca);
        apb(1'b1, `CTU_ADDR_CTRL0, 32'h0);
        apb(1'b1, `CTU_ADDR_FLAGS, 32'h3);
        apb(1'b1, `CTU_ADDR_CMPA_LO, {24'h0, ca[7:0]});
        apb(1'b1, `CTU_ADDR_CMPA_HI, {30'h0, ca[9:8]});
        apb(1'b0, `CTU_ADDR_CMPA_HI, 32'h0);
        chk(rd, {30'h0, ca[9:8]}, "compare high");
        apb(1'b0, `CTU_ADDR_CMPA_LO, 32'h0);
        chk(rd, {24'h0, ca[7:0]}, "compare low");
        apb(1'b1, `CTU_ADDR_CTRL1, {24'h0, c1});
        apb(1'b1, `CTU_ADDR_CTRL0, {24'h0, c0});
    endtask

    task automatic wait_fl(input logic sel, output int c);
        c = 0;
        while (((sel ? fp : fa) !== 1'b1) && c < 3000) begin
            @(posedge pclk);
            c++;
        end
    endtask

    function automatic logic exp_pin(int f, logic oc, logic pol);
        return (f == 0 ? oc : f == 2) ^ pol;
    endfunction

    function automatic int exp_hi(int k, logic [9:0] d);
        int t[5] = '{2 * d, 256, 0, 256, 128};
        return (k == 0 && d >= 10'h080) ? 256 : t[k];
    endfunction

    function automatic int exp_cnt(int k);
        int d[8] = '{4, 1, 32, 128, 16, 16, 8, 8};
        return 640 / d[k];
    endfunction

    ////////////////////////////////////////////////////////////////
    initial begin
        #400_000;
        error_cnt++;
        $display("ERROR %0t watchdog expired", $time);
        print_verdict();
    end

    initial begin
        void'($urandom(55734));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk(rd, 32'h0, "reset value");
        end
        apb(1'b0, 12'h01C, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        apb(1'b1, `CTU_ADDR_CNT_LO, 32'hFF);
        apb(1'b0, `CTU_ADDR_CNT_LO, 32'h0);
        chk(rd, 32'h0, "counter write ignored");
        for (int f = 0; f < 3; f++) begin
            o = 1'($urandom);
            p = 1'($urandom);
            cmp = 10'(100 + $urandom % 800);
            cfg(8'h19, {2'h0, 2'(f), o, p, 2'h1}, cmp);
            wait_fl(1'b0, n);
            chk(32'(n inside {[cmp : cmp + 6]}), 32'h1, "compare match time");
            repeat (3) @(posedge pclk);
            chk({31'h0, pin}, {31'h0, exp_pin(f, o, p)}, "pin after match");
            chk({31'h0, fp}, 32'h0, "period flag quiet");
            chk({31'h0, pin_en}, 32'h0, "pin driven");
            rdcnt(v);
            chk(32'(v <= cmp), 32'h1, "cleared at compare");
        end
        for (int k = 0; k < 3; k++) begin
            per = (k == 0) ? 3'h0 : 3'(1 + $urandom % 7);
            cfg({4'h1, 1'b1, per}, 8'hC0, 10'h000);
            wait_fl(1'b1, n);
            e = (per == 3'h0 ? 8 : int'(per)) * 128;
            chk(32'(n inside {[e - 2 : e + 4]}), 32'h1, "period match time");
            chk({31'h0, irq}, 32'h1, "irq on clear");
            chk({31'h0, pin_en}, 32'h1, "pin unused");
        end
        cfg(8'h18, 8'hC0, 10'h000);
        repeat (50) @(posedge pclk);
        apb(1'b1, `CTU_ADDR_CTRL0, 32'h98);
        rdcnt(a);
        repeat (20) @(posedge pclk);
        rdcnt(v);
        chk({22'h0, v}, {22'h0, a}, "paused hold");
        chk({31'h0, pwr}, 32'h1, "paused powered");
        apb(1'b1, `CTU_ADDR_CTRL0, 32'h18);
        rdcnt(v);
        chk(32'(v > a), 32'h1, "resumed");
        apb(1'b1, `CTU_ADDR_CTRL0, 32'h10);
        rdcnt(a);
        repeat (20) @(posedge pclk);
        rdcnt(v);
        chk({22'h0, v}, {22'h0, a}, "off hold");
        chk({31'h0, pwr}, 32'h0, "off unpowered");
        apb(1'b1, `CTU_ADDR_CTRL0, 32'h18);
        rdcnt(v);
        chk(32'(v < 10'h010), 32'h1, "on clears");
        for (int k = 0; k < 5; k++) begin
            cmp = (k == 1) ? 10'h0C8 : (k == 4 ? 10'h200 : 10'h020);
            cfg(8'h19, {2'h2, 2'(k < 2 || k == 4 ? 2 : k - 2), 1'b1, 1'b0, k == 4, 1'b1}, cmp);
            repeat (4) @(posedge pclk);
            n = 0;
            repeat (k == 4 ? 512 : 256) begin
                @(posedge pclk);
                n += int'(pin === 1'b1);
            end
            e = exp_hi(k, cmp);
            chk(32'(n inside {[e - 3 : e + 3]}), 32'h1, "pwm high time");
        end
        for (int k = 0; k < 8; k++) begin
            cfg({1'b0, 3'(k), 1'b1, 3'h0}, 8'hC0, 10'h000);
            repeat (160) begin
                repeat (4) @(posedge pclk);
                if (k > 5)
                    clk_in.ext_pin <= ~clk_in.ext_pin;
            end
            rdcnt(v);
            e = exp_cnt(k);
            chk(32'(int'(v) inside {[e - 4 : e + 4]}), 32'h1, "clock source count");
        end
        print_verdict();
    end
endmodule // ctu_timer_tb_top
